// ---- lane_cfg_host.sv ----
// management host model driving the lane config byte port
`timescale 1ns/10ps
module lane_cfg_host (
  input wire clock,
  output reg regWrEn,
  output reg regRdEn,
  output reg [7:0] regAddr,
  output reg [7:0] regWrData,
  input wire [7:0] regRdData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // one-cycle strobes, changed only at the falling edge
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clock);
      regAddr = a;
      regWrData = d; // callers keep reserved bits and codes clear
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clock);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      d = regRdData;
    end
  endtask
endmodule // lane_cfg_host

// ---- lane_signal_config_defines.vh ----
// offsets, field positions, reset values and codes of the lane config bytes
`ifndef LANE_SIGNAL_CONFIG_DEFINES_VH
`define LANE_SIGNAL_CONFIG_DEFINES_VH

`define LANE2_TX_EMPHASIS_CTRL_ADDR 8'h1F
`define LANE2_QUIET_THRESHOLD_ADDR 8'h20
`define LANE3_QUIET_SPEED_SELECT_ADDR 8'h23
`define LANE3_RX_BOOST_CTRL_ADDR 8'h24
`define LANE3_TX_SWING_CTRL_ADDR 8'h25

`define LANE2_TX_EMPHASIS_CTRL_RST 8'h03
`define LANE2_QUIET_THRESHOLD_RST 8'h00
`define LANE3_QUIET_SPEED_SELECT_RST 8'h00
`define LANE3_RX_BOOST_CTRL_RST 8'h20
`define LANE3_TX_SWING_CTRL_RST 8'h03

`define EMPH_STYLE_BIT 7
`define EMPH_LEVEL_MSB 6
`define THR_DEASSERT_MSB 3
`define THR_DEASSERT_LSB 2
`define THR_ASSERT_MSB 1
`define THR_ASSERT_LSB 0
`define QUIET_AUTO_BIT 5
`define QUIET_MUTE_BIT 4
`define SPEED_AUTO_BIT 1
`define SPEED_SEL_BIT 0
`define BOOST_EN_BIT 5
`define GAIN_STAGE_MSB 4
`define GAIN_STAGE_LSB 3
`define BOOST_LEVEL_MSB 2
`define SWING_MSB 5

// writable masks: reserved bits always read zero
`define EMPH_WMASK 8'hFF
`define THR_WMASK 8'h0F
`define QSPD_WMASK 8'h33
`define BOOST_WMASK 8'h3F
`define SWING_WMASK 8'h3F

// emphasis strap code to register byte
`define EMPH_STRAP_00 8'h01
`define EMPH_STRAP_01 8'hE8
`define EMPH_STRAP_11 8'h88
`define EMPH_STRAP_0F 8'h90
`define EMPH_STRAP_1F 8'hA0
`define EMPH_STRAP_F0 8'hA0
`define EMPH_STRAP_F1 8'hA0
`define EMPH_STRAP_FF 8'hC0
`define EMPH_RESERVED 8'hC0

// equalizer strap code to register byte
`define BOOST_STRAP_FF 8'h20
`define BOOST_STRAP_11 8'h2A
`define BOOST_STRAP_00 8'h30
`define BOOST_STRAP_F0 8'h32
`define BOOST_STRAP_10 8'h39
`define BOOST_STRAP_F1 8'h35
`define BOOST_STRAP_01 8'h37
`define BOOST_STRAP_0F 8'h3B
`define BOOST_STRAP_1F 8'h3D

// three-level strap pin encoding
`define STRAP_LOW 2'h0
`define STRAP_HIGH 2'h1
`define STRAP_FLOAT 2'h2

`endif

// ---- lane_signal_config_regs.v ----
// lane 2/3 signal conditioning configuration bytes behind the management port
`timescale 1ns/10ps
`include "lane_signal_config_defines.vh"

// Operation
// - emphasis bit7 picks compatibility or enhanced style
// - emphasis bits 6:0 set de-emphasis level
// - 01h gives 0 dB, E8h gives -3.5 dB
// - 88h -6, 90h -9, A0h -12 dB
// - strap pins map to same emphasis bytes
// - threshold bits 3:2 deassert, 1:0 assert
// - threshold codes 00..11 select mV pairs
// - quiet auto bit5 overrides manual bit4
// - manual bit4: 0 active, 1 muted idle
// - speed auto bit1 overrides manual bit0
// - speed bit0: 0 slow rate, 1 fast
// - equalizer: enable, gain stage, boost level
// - 24 levels: 3 stages, 8 boosts
// - 20h bypasses equalizer, reset default
// - equalizer straps map to register codes
// - swing codes 03h/07h/0Fh/1Fh, 600..1200 mV
module lane_signal_config_regs (
  input wire clock,
  input wire srst,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  output wire regAddrHit,
  input wire strapLoad,
  input wire [1:0] tx_emphasis_strap_pins1,
  input wire [1:0] tx_emphasis_strap_pins0,
  input wire [1:0] rx_boost_strap_pins1,
  input wire [1:0] rx_boost_strap_pins0,
  input wire autoQuietDetect,
  input wire autoSpeedDetect,
  output reg emphasisEnhanced,
  output reg [6:0] emphasisLevel,
  output reg emphasisReserved,
  output reg [1:0] quietDeassertSel,
  output reg [1:0] quietAssertSel,
  output reg lane3Muted,
  output reg lane3SquelchEnable,
  output reg lane3FastRate,
  output reg boostEnable,
  output reg [1:0] gain_stage_select,
  output reg [2:0] boost_level,
  output reg [5:0] tx_swing
);

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] emphasis_ff;
  reg [7:0] threshold_ff;
  reg [7:0] quietSpeed_ff;
  reg [7:0] boost_ff;
  reg [7:0] swing_ff;
  reg [7:0] nxt_emphasis;
  reg [7:0] nxt_boost;
  reg [7:0] emphStrapByte;
  reg [7:0] boostStrapByte;
  reg strapApply_ff;

  wire hitEmph = (regAddr == `LANE2_TX_EMPHASIS_CTRL_ADDR);
  wire hitThr = (regAddr == `LANE2_QUIET_THRESHOLD_ADDR);
  wire hitQspd = (regAddr == `LANE3_QUIET_SPEED_SELECT_ADDR);
  wire hitBoost = (regAddr == `LANE3_RX_BOOST_CTRL_ADDR);
  wire hitSwing = (regAddr == `LANE3_TX_SWING_CTRL_ADDR);

  assign regAddrHit = hitEmph | hitThr | hitQspd | hitBoost | hitSwing;

  ////////////////////////////////////////////////////////////////////////////
  // strap decode: each three-level pin pair names one register byte
  always @* begin
    case ({tx_emphasis_strap_pins1, tx_emphasis_strap_pins0})
      {`STRAP_LOW, `STRAP_LOW}: emphStrapByte = `EMPH_STRAP_00;
      {`STRAP_LOW, `STRAP_HIGH}: emphStrapByte = `EMPH_STRAP_01;
      {`STRAP_HIGH, `STRAP_HIGH}: emphStrapByte = `EMPH_STRAP_11;
      {`STRAP_LOW, `STRAP_FLOAT}: emphStrapByte = `EMPH_STRAP_0F;
      {`STRAP_HIGH, `STRAP_FLOAT}: emphStrapByte = `EMPH_STRAP_1F;
      {`STRAP_FLOAT, `STRAP_LOW}: emphStrapByte = `EMPH_STRAP_F0;
      {`STRAP_FLOAT, `STRAP_HIGH}: emphStrapByte = `EMPH_STRAP_F1;
      {`STRAP_FLOAT, `STRAP_FLOAT}: emphStrapByte = `EMPH_STRAP_FF;
      default: emphStrapByte = `LANE2_TX_EMPHASIS_CTRL_RST;
    endcase
  end

  always @* begin
    case ({rx_boost_strap_pins1, rx_boost_strap_pins0})
      {`STRAP_FLOAT, `STRAP_FLOAT}: boostStrapByte = `BOOST_STRAP_FF;
      {`STRAP_HIGH, `STRAP_HIGH}: boostStrapByte = `BOOST_STRAP_11;
      {`STRAP_LOW, `STRAP_LOW}: boostStrapByte = `BOOST_STRAP_00;
      {`STRAP_FLOAT, `STRAP_LOW}: boostStrapByte = `BOOST_STRAP_F0;
      {`STRAP_HIGH, `STRAP_LOW}: boostStrapByte = `BOOST_STRAP_10;
      {`STRAP_FLOAT, `STRAP_HIGH}: boostStrapByte = `BOOST_STRAP_F1;
      {`STRAP_LOW, `STRAP_HIGH}: boostStrapByte = `BOOST_STRAP_01;
      {`STRAP_LOW, `STRAP_FLOAT}: boostStrapByte = `BOOST_STRAP_0F;
      {`STRAP_HIGH, `STRAP_FLOAT}: boostStrapByte = `BOOST_STRAP_1F;
      default: boostStrapByte = `LANE3_RX_BOOST_CTRL_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // straps are caught at the first clock after reset release, never under reset
  always @(posedge clock) begin
    if (srst) begin
      strapApply_ff <= 1'b1;
    end else begin
      strapApply_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] nxt_threshold;
  reg [7:0] nxt_quietSpeed;
  reg [7:0] nxt_swing;
  reg [7:0] rdMux;

  wire wrEmph = regWrEn & hitEmph;
  wire wrThr = regWrEn & hitThr;
  wire wrQspd = regWrEn & hitQspd;
  wire wrBoost = regWrEn & hitBoost;
  wire wrSwing = regWrEn & hitSwing;
  wire strapTake = strapApply_ff | strapLoad;

  // a bus write in the same cycle as a strap load wins
  always @* begin
    nxt_emphasis = emphasis_ff;
    if (strapTake) begin
      nxt_emphasis = emphStrapByte;
    end
    if (wrEmph) begin
      nxt_emphasis = regWrData & `EMPH_WMASK;
    end
  end

  always @* begin
    nxt_boost = boost_ff;
    if (strapTake) begin
      nxt_boost = boostStrapByte;
    end
    if (wrBoost) begin
      nxt_boost = regWrData & `BOOST_WMASK;
    end
  end

  // reserved bits are dropped so a careless host cannot set them
  always @* begin
    nxt_threshold = threshold_ff;
    if (wrThr) begin
      nxt_threshold = regWrData & `THR_WMASK;
    end
  end

  always @* begin
    nxt_quietSpeed = quietSpeed_ff;
    if (wrQspd) begin
      nxt_quietSpeed = regWrData & `QSPD_WMASK;
    end
  end

  always @* begin
    nxt_swing = swing_ff;
    if (wrSwing) begin
      nxt_swing = regWrData & `SWING_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored bytes
  always @(posedge clock) begin
    if (srst) begin
      emphasis_ff <= `LANE2_TX_EMPHASIS_CTRL_RST;
    end else begin
      emphasis_ff <= nxt_emphasis;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      threshold_ff <= `LANE2_QUIET_THRESHOLD_RST;
    end else begin
      threshold_ff <= nxt_threshold;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      quietSpeed_ff <= `LANE3_QUIET_SPEED_SELECT_RST;
    end else begin
      quietSpeed_ff <= nxt_quietSpeed;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      boost_ff <= `LANE3_RX_BOOST_CTRL_RST;
    end else begin
      boost_ff <= nxt_boost;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      swing_ff <= `LANE3_TX_SWING_CTRL_RST;
    end else begin
      swing_ff <= nxt_swing;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data registered; unmapped addresses return zero
  always @* begin
    case (regAddr)
      `LANE2_TX_EMPHASIS_CTRL_ADDR: rdMux = emphasis_ff;
      `LANE2_QUIET_THRESHOLD_ADDR: rdMux = threshold_ff;
      `LANE3_QUIET_SPEED_SELECT_ADDR: rdMux = quietSpeed_ff;
      `LANE3_RX_BOOST_CTRL_ADDR: rdMux = boost_ff;
      `LANE3_TX_SWING_CTRL_ADDR: rdMux = swing_ff;
      default: rdMux = 8'h00;
    endcase
  end

  // held between reads so a slow host can pick it up late
  always @(posedge clock) begin
    if (srst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog controls follow the stored bytes, or the auto detect inputs in auto mode, one cycle later
  always @(posedge clock) begin
    if (srst) begin
      emphasisEnhanced <= 1'b0;
    end else begin
      emphasisEnhanced <= emphasis_ff[`EMPH_STYLE_BIT];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      emphasisLevel <= 7'h03;
    end else begin
      emphasisLevel <= emphasis_ff[`EMPH_LEVEL_MSB:0];
    end
  end

  // reserved byte is flagged, the analog side still follows it like any other byte
  always @(posedge clock) begin
    if (srst) begin
      emphasisReserved <= 1'b0;
    end else begin
      emphasisReserved <= (emphasis_ff == `EMPH_RESERVED);
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      quietDeassertSel <= 2'h0;
    end else begin
      quietDeassertSel <=
        threshold_ff[`THR_DEASSERT_MSB:`THR_DEASSERT_LSB];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      quietAssertSel <= 2'h0;
    end else begin
      quietAssertSel <= threshold_ff[`THR_ASSERT_MSB:`THR_ASSERT_LSB];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      lane3Muted <= 1'b0;
    end else if (quietSpeed_ff[`QUIET_AUTO_BIT]) begin
      lane3Muted <= autoQuietDetect;
    end else begin
      lane3Muted <= quietSpeed_ff[`QUIET_MUTE_BIT];
    end
  end

  // manual mode keeps squelch off so the output never drops by itself
  always @(posedge clock) begin
    if (srst) begin
      lane3SquelchEnable <= 1'b0;
    end else begin
      lane3SquelchEnable <= quietSpeed_ff[`QUIET_AUTO_BIT];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      lane3FastRate <= 1'b0;
    end else if (quietSpeed_ff[`SPEED_AUTO_BIT]) begin
      lane3FastRate <= autoSpeedDetect;
    end else begin
      lane3FastRate <= quietSpeed_ff[`SPEED_SEL_BIT];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      boostEnable <= 1'b1;
    end else begin
      boostEnable <= boost_ff[`BOOST_EN_BIT];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      gain_stage_select <= 2'h0;
    end else begin
      gain_stage_select <=
        boost_ff[`GAIN_STAGE_MSB:`GAIN_STAGE_LSB];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      boost_level <= 3'h0;
    end else begin
      boost_level <= boost_ff[`BOOST_LEVEL_MSB:0];
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      tx_swing <= 6'h03;
    end else begin
      tx_swing <= swing_ff[`SWING_MSB:0];
    end
  end

endmodule // lane_signal_config_regs

// ---- lane_signal_config_regs_props.sv ----
// assertions on the lane config byte block ports
`timescale 1ns/10ps
module lane_signal_config_regs_props (
  input wire clock,
  input wire srst,
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  input wire regAddrHit,
  input wire emphasisEnhanced,
  input wire [6:0] emphasisLevel,
  input wire [1:0] quietDeassertSel,
  input wire [1:0] quietAssertSel,
  input wire lane3Muted,
  input wire lane3FastRate,
  input wire boostEnable,
  input wire [1:0] gain_stage_select,
  input wire [2:0] boost_level,
  input wire [5:0] tx_swing
);
  wire wrEmph = regWrEn && regAddr == 8'h1F;
  wire wrQs = regWrEn && regAddr == 8'h23;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  a_style_bit: assert property (wrEmph |->
    ##2 emphasisEnhanced == $past(regWrData[7], 2)) else $error("style");
  a_level_field: assert property (wrEmph |->
    ##2 emphasisLevel == $past(regWrData[6:0], 2)) else $error("level");
  a_thresh_fields: assert property (regWrEn && regAddr == 8'h20 |->
    ##2 {quietDeassertSel, quietAssertSel} == $past(regWrData[3:0], 2))
    else $error("threshold");
  a_mute_manual: assert property (wrQs && !regWrData[5] |->
    ##2 lane3Muted == $past(regWrData[4], 2)) else $error("mute");
  a_rate_manual: assert property (wrQs && !regWrData[1] |->
    ##2 lane3FastRate == $past(regWrData[0], 2)) else $error("rate");
  a_boost_fields: assert property (regWrEn && regAddr == 8'h24 |->
    ##2 {boostEnable, gain_stage_select, boost_level} ==
    $past(regWrData[5:0], 2)) else $error("boost");
  a_swing_field: assert property (regWrEn && regAddr == 8'h25 |->
    ##2 tx_swing == $past(regWrData[5:0], 2)) else $error("swing");
  a_unmapped_read: assert property (regRdEn && !regAddrHit |->
    ##1 regRdData == 8'h00) else $error("unmapped read");
endmodule // lane_signal_config_regs_props
bind lane_signal_config_regs
  lane_signal_config_regs_props lane_signal_config_regs_props_i (.*);

// ---- lane_signal_config_regs_tb_top.sv ----
// self-checking bench for the lane config byte block
`timescale 1ns/10ps
`include "lane_signal_config_defines.vh"
module lane_signal_config_regs_tb_top;
  reg clock;
  reg srst;
  reg strapLoad;
  reg autoQuietDetect;
  reg autoSpeedDetect;
  reg [1:0] tx_emphasis_strap_pins1, tx_emphasis_strap_pins0;
  reg [1:0] rx_boost_strap_pins1, rx_boost_strap_pins0;
  wire regWrEn, regRdEn, regAddrHit, emphasisEnhanced, emphasisReserved;
  wire lane3Muted, lane3SquelchEnable, lane3FastRate, boostEnable;
  wire [7:0] regAddr, regWrData, regRdData;
  wire [6:0] emphasisLevel;
  wire [1:0] quietDeassertSel, quietAssertSel, gain_stage_select;
  wire [2:0] boost_level;
  wire [5:0] tx_swing;
  integer n_fail = 0;
  integer samples_checked = 0;
  integer i;
  reg [7:0] rv;
  reg [7:0] emTab [0:4];
  lane_signal_config_regs lane_signal_config_regs_i (.*);
  lane_cfg_host lane_cfg_host_i (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task chk(input string nm, input [7:0] s, input [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      lane_cfg_host_i.rd(a, rv);
      chk("readback", rv, e);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_defaults;
    begin
      rdc(8'h1F, 8'h01);
      rdc(8'h20, 8'h00);
      rdc(8'h23, 8'h00);
      rdc(8'h24, 8'h20);
      rdc(8'h25, 8'h03);
      rdc(8'h21, 8'h00);
      chk("hit", {7'h00, regAddrHit}, 8'h00);
    end
  endtask
  task t_emph;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        lane_cfg_host_i.wr(8'h1F, emTab[i]);
        rdc(8'h1F, emTab[i]);
        chk("level", {1'b0, emphasisLevel}, {1'b0, emTab[i][6:0]});
        chk("style", {7'h00, emphasisEnhanced}, {7'h00, emTab[i][7]});
        chk("rsvd", {7'h00, emphasisReserved}, 8'h00);
        chk("hit", {7'h00, regAddrHit}, 8'h01);
      end
    end
  endtask
  task t_lane3;
    begin
      lane_cfg_host_i.wr(8'h20, 8'h09);
      rdc(8'h20, 8'h09);
      chk("thr", {4'h0, quietDeassertSel, quietAssertSel}, 8'h09);
      lane_cfg_host_i.wr(8'h23, 8'h11);
      rdc(8'h23, 8'h11);
      chk("manual", {6'h00, lane3Muted, lane3FastRate}, 8'h03);
      // auto mode must ignore the manual bits written alongside
      lane_cfg_host_i.wr(8'h23, 8'h32);
      rdc(8'h23, 8'h32);
      chk("auto", {5'h00, lane3SquelchEnable, lane3Muted, lane3FastRate},
        8'h05);
      lane_cfg_host_i.wr(8'h24, 8'h3B);
      rdc(8'h24, 8'h3B);
      chk("eq", {2'b00, boostEnable, gain_stage_select, boost_level},
        8'h3B);
      lane_cfg_host_i.wr(8'h25, 8'h1F);
      rdc(8'h25, 8'h1F);
      chk("swing", {2'b00, tx_swing}, 8'h1F);
    end
  endtask
  task t_strap;
    begin
      tx_emphasis_strap_pins0 = `STRAP_HIGH;
      rx_boost_strap_pins0 = `STRAP_FLOAT;
      rx_boost_strap_pins1 = `STRAP_LOW;
      strapLoad = 1'b1;
      @(negedge clock);
      strapLoad = 1'b0;
      rdc(8'h1F, 8'hE8);
      rdc(8'h24, 8'h3B);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    strapLoad = 1'b0;
    autoQuietDetect = 1'b0;
    autoSpeedDetect = 1'b1;
    tx_emphasis_strap_pins1 = `STRAP_LOW;
    tx_emphasis_strap_pins0 = `STRAP_LOW;
    rx_boost_strap_pins1 = `STRAP_FLOAT;
    rx_boost_strap_pins0 = `STRAP_FLOAT;
    emTab[0] = 8'h01;
    emTab[1] = 8'hE8;
    emTab[2] = 8'h88;
    emTab[3] = 8'h90;
    emTab[4] = 8'hA0;
    repeat (10) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    t_defaults;
    t_emph;
    t_lane3;
    t_strap;
    close_out;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    close_out;
  end
endmodule // lane_signal_config_regs_tb_top
